// ===== odtc_pkg.sv
/*
 package for the odt control pair: termination codes, link timing counts and
 mode register field positions. assumes a single 10 mhz system clock.
*/
package odtc_pkg;
	localparam int ODTC_CLK_NS = 100;
	// mode register field positions
	localparam int ODTC_MR1_DLL_EN_BIT = 0;
	localparam int ODTC_MR5_BUF_DIS_BIT = 5;
	localparam logic [2:0] ODTC_WR_TERM_OFF = 3'h0;
	// termination select codes
	typedef enum logic [1:0] {
		ODTC_TERM_PARK = 2'h0,
		ODTC_TERM_NOM = 2'h1,
		ODTC_TERM_WR = 2'h2
	} odtc_term_t;
	// timing figures in cycles of the link
	localparam int ODTC_TDODTOFF_CYC = 7;
	localparam int ODTC_TCPDED_CYC = 4;
	localparam int ODTC_TXP_CYC = 6;
	localparam int ODTC_WL_CYC = 9;
	localparam int ODTC_TANPD_CYC = ODTC_WL_CYC - 1;
	// refresh interval in extended and normal temperature
	localparam int ODTC_TREFI_EXT_NS = 3900;
	localparam int ODTC_TREFI_NORM_NS = 7800;
	localparam int ODTC_TREFI_EXT_CYC = ODTC_TREFI_EXT_NS / ODTC_CLK_NS;
	localparam int ODTC_TREFI_NORM_CYC = ODTC_TREFI_NORM_NS / ODTC_CLK_NS;
	localparam int ODTC_CNT_W = 8;
endpackage

// ===== odtc_link_if.sv
/*
 link between controller and device: odt, cke, mode bits, refresh strobe.
 odt is modelled as a pin the controller can release (float).
*/
`timescale 1ns/1ns
interface odtc_link_if;
	logic odt_o;
	logic odt_oe;
	logic cke;
	logic dll_en;
	logic buf_dis_en;
	logic [2:0] wr_term;
	logic refresh;
	modport ctrl (output odt_o, output odt_oe, output cke, output dll_en,
		output buf_dis_en, output wr_term, output refresh);
	modport dev (input odt_o, input odt_oe, input cke, input dll_en,
		input buf_dis_en, input wr_term, input refresh);
endinterface

// ===== odtc_device.sv
/*
 device end: selects park, nominal or write termination from sampled odt.
 assumes link signals are synchronous to sys_clk (one clock drives both ends).
*/
// Behaviour
// - dll off selects asynchronous odt mode
// - async mode: odt drives nominal without latency
// - sampled high starts park to nominal
// - sampled low starts nominal to park
// - buffer disable: no nominal in power down
// - controller holds odt steady around entry
// - controller may float odt after tcpded
// - odt near entry may give either termination
// - controller drives odt low until txp
// - extended temperature doubles refresh rate; normal rate kept when single_rate_ref is set
// - dynamic write termination off when dll off
// - odt low without write gives park
`timescale 1ns/1ns
module odtc_device
	import odtc_pkg::*;
#(
	parameter int DODT_LAT = ODTC_TDODTOFF_CYC
) (
	input wire logic sys_clk,
	input wire logic rstn,
	odtc_link_if.dev link,
	input wire logic wr_active,
	output logic [1:0] term_sel,
	output logic async_mode,
	output logic power_down,
	output logic wr_term_err
);
	typedef struct packed {
		logic [DODT_LAT-1:0] odt_pipe;
		logic [1:0] term;
		logic async;
		logic pd;
		logic err;
	} odtc_dev_st_t;
	odtc_dev_st_t st_reg, st_next;
	logic odt_in;

	// a floating pin reads low; only matters while buffer is disabled
	assign odt_in = link.odt_oe & link.odt_o;

	// next state: latency pipe, power-down tracking, termination choice
	always_comb begin
		st_next = st_reg;
		st_next.async = ~link.dll_en;
		st_next.pd = ~link.cke;
		st_next.odt_pipe = {st_reg.odt_pipe[DODT_LAT-2:0], odt_in};
		// dynamic termination must be disabled when dll is off
		st_next.err = ~link.dll_en && (link.wr_term != ODTC_WR_TERM_OFF);
		if (wr_active && link.dll_en && link.wr_term != ODTC_WR_TERM_OFF) begin
			st_next.term = ODTC_TERM_WR;
		end else if (link.buf_dis_en && ~link.cke) begin
			st_next.term = ODTC_TERM_PARK;
		end else if (~link.dll_en) begin
			// sampled edge drives nominal directly, no latency
			st_next.term = odt_in ? ODTC_TERM_NOM : ODTC_TERM_PARK;
		end else begin
			// synchronous mode keeps the direct odt latency
			st_next.term = st_reg.odt_pipe[DODT_LAT-1] ? ODTC_TERM_NOM
				: ODTC_TERM_PARK;
		end
	end

	// state register
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign term_sel = st_reg.term;
	assign async_mode = st_reg.async;
	assign power_down = st_reg.pd;
	assign wr_term_err = st_reg.err;
endmodule

// ===== odtc_controller.sv
/*
 controller end: drives odt and cke, sequences power-down entry and exit
 with odt hold/float windows, and issues refresh strobes.
 assumes request and config inputs are already synchronous to sys_clk.
*/
`timescale 1ns/1ns
module odtc_controller
	import odtc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rstn,
	odtc_link_if.ctrl link,
	input wire logic odt_req,
	input wire logic pd_req,
	input wire logic dll_en_cfg,
	input wire logic buf_dis_cfg,
	input wire logic ext_temp,
	input wire logic single_rate_ref,
	output logic busy
);
	typedef enum logic [2:0] {S_RUN, S_HOLD, S_ENTER, S_FLOAT, S_EXIT} odtc_cst_t;
	typedef struct packed {
		odtc_cst_t st;
		logic [ODTC_CNT_W-1:0] cnt;
		logic [ODTC_CNT_W-1:0] ref_cnt;
		logic odt;
		logic oe;
		logic cke;
		logic ref_p;
		logic busy;
	} odtc_ctl_st_t;
	odtc_ctl_st_t s_reg, s_next;
	logic [ODTC_CNT_W-1:0] ref_lim;

	// refresh doubled in extended temperature unless part is single rate
	assign ref_lim = (ext_temp && !single_rate_ref) ? ODTC_CNT_W'(ODTC_TREFI_EXT_CYC - 1)
		: ODTC_CNT_W'(ODTC_TREFI_NORM_CYC - 1);

	// power-down sequencer and refresh timer
	always_comb begin
		s_next = s_reg;
		s_next.ref_p = 1'b0;
		if (s_reg.ref_cnt >= ref_lim) begin
			s_next.ref_cnt = '0;
			s_next.ref_p = s_reg.cke;
		end else begin
			s_next.ref_cnt = s_reg.ref_cnt + 1'b1;
		end
		unique case (s_reg.st)
			S_RUN: begin
				s_next.odt = odt_req;
				s_next.oe = 1'b1;
				s_next.cke = 1'b1;
				if (pd_req) begin
					s_next.st = S_HOLD;
					s_next.cnt = ODTC_CNT_W'(ODTC_TDODTOFF_CYC + 1);
				end
			end
			S_HOLD: begin
				// odt frozen from tdodtoff+2 cycles before cke low
				if (s_reg.cnt == '0) begin
					s_next.cke = 1'b0;
					s_next.st = S_ENTER;
					s_next.cnt = ODTC_CNT_W'(ODTC_TCPDED_CYC);
				end else begin
					s_next.cnt = s_reg.cnt - 1'b1;
				end
			end
			S_ENTER: begin
				if (s_reg.cnt == '0) begin
					s_next.st = S_FLOAT;
					s_next.oe = ~buf_dis_cfg;
				end else begin
					s_next.cnt = s_reg.cnt - 1'b1;
				end
			end
			S_FLOAT: begin
				if (!pd_req) begin
					// re-drive odt low together with cke high
					s_next.cke = 1'b1;
					s_next.oe = 1'b1;
					s_next.odt = 1'b0;
					s_next.st = S_EXIT;
					s_next.cnt = ODTC_CNT_W'(ODTC_TXP_CYC);
				end
			end
			S_EXIT: begin
				if (s_reg.cnt == '0) begin
					s_next.st = S_RUN;
				end else begin
					s_next.cnt = s_reg.cnt - 1'b1;
				end
			end
		endcase
		s_next.busy = (s_next.st != S_RUN);
	end

	// state register
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			s_reg <= '{st: S_RUN, cnt: '0, ref_cnt: '0, odt: 1'b0, oe: 1'b1,
				cke: 1'b0, ref_p: 1'b0, busy: 1'b0};
		end else begin
			s_reg <= s_next;
		end
	end

	// mode bits: write termination cleared whenever dll is off
	assign link.dll_en = dll_en_cfg;
	assign link.buf_dis_en = buf_dis_cfg;
	assign link.wr_term = dll_en_cfg ? 3'h1 : ODTC_WR_TERM_OFF;
	assign link.odt_o = s_reg.odt;
	assign link.odt_oe = s_reg.oe;
	assign link.cke = s_reg.cke;
	assign link.refresh = s_reg.ref_p;
	assign busy = s_reg.busy;
endmodule

// ===== odtc_assertions.sv
/* link checker: controller duties on the odt wire around power-down.
 assumes one clock; link signals joined by name. */
`timescale 1ns/1ns
module odtc_assertions
	import odtc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic odt_o,
	input wire logic odt_oe,
	input wire logic cke,
	input wire logic dll_en,
	input wire logic buf_dis_en,
	input wire logic [2:0] wr_term,
	input wire logic refresh
);
	// one domain, so a single clock and reset serve every check
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	logic odt_last;
	logic [3:0] hold_cnt;
	// cycles odt stayed driven and unchanged; saturates so a long idle cannot wrap
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			odt_last <= 1'b0;
			hold_cnt <= 4'h0;
		end else begin
			odt_last <= odt_o;
			if (!odt_oe || odt_o != odt_last) begin
				hold_cnt <= 4'h0;
			end else if (hold_cnt != 4'hF) begin
				hold_cnt <= hold_cnt + 4'h1;
			end
		end
	end
	property p_wr; !dll_en |-> wr_term == 3'h0; endproperty
	a_wr: assert property (p_wr) else $error("wr_term on");
	// endpoints alone would miss a glitch inside the window, so count the hold
	property p_pre;
		$fell(cke) |-> odt_oe && $stable(odt_o) && hold_cnt >= 4'(ODTC_TDODTOFF_CYC);
	endproperty
	a_pre: assert property (p_pre) else $error("odt moved pre");
	property p_post; $fell(cke) |-> ##1 (odt_oe && $stable(odt_o)) [*4]; endproperty
	a_post: assert property (p_post) else $error("odt moved post");
	property p_early; $fell(odt_oe) |-> !cke && $past(cke, 4) == 1'b0; endproperty
	a_early: assert property (p_early) else $error("float early");
	property p_late; $fell(cke) && buf_dis_en |-> ##5 (cke || !odt_oe); endproperty
	a_late: assert property (p_late) else $error("no float");
	property p_float; !odt_oe |-> !cke && buf_dis_en; endproperty
	a_float: assert property (p_float) else $error("float out");
	property p_exit; $rose(cke) && !$past(odt_oe) |-> (odt_oe && !odt_o) [*6]; endproperty
	a_exit: assert property (p_exit) else $error("odt exit");
	property p_ref; refresh |-> cke ##1 !refresh; endproperty
	a_ref: assert property (p_ref) else $error("refresh");
	c_entry: cover property ($fell(cke));
	c_float: cover property ($fell(odt_oe));
	c_exit: cover property ($rose(cke) && !$past(odt_oe));
endmodule

// ===== test_odtc.sv
/* bench for the odt pair joined by the link.
 assumes 10 mhz sys_clk; inputs move on the falling edge. */
`timescale 1ns/1ns
module test_odt_async_and_powerdown_control;
	import odtc_pkg::*;
	logic sys_clk = 0, rstn = 0, odt_req = 0, pd_req = 0, dll = 0, bdis = 0, ext = 1, wr = 0;
	logic srr = 0;
	logic [1:0] term_sel;
	logic async_mode, power_down, wr_term_err, busy;
	int err_count = 0, checks = 0, n;
	// rows: dll, odt, write, expected termination
	localparam logic [4:0] ROWS [5] = '{5'h00, 5'h09, 5'h19, 5'h1E, 5'h10};
	odtc_link_if link ();
	odtc_controller odtc_controller_inst (.sys_clk(sys_clk), .rstn(rstn), .link(link),
		.odt_req(odt_req), .pd_req(pd_req), .dll_en_cfg(dll), .buf_dis_cfg(bdis),
		.ext_temp(ext), .single_rate_ref(srr), .busy(busy));
	odtc_device odtc_device_inst (.sys_clk(sys_clk), .rstn(rstn), .link(link), .wr_active(wr),
		.term_sel(term_sel), .async_mode(async_mode), .power_down(power_down),
		.wr_term_err(wr_term_err));
	odtc_assertions odtc_assertions_inst (.sys_clk(sys_clk), .rstn(rstn), .odt_o(link.odt_o),
		.odt_oe(link.odt_oe), .cke(link.cke), .dll_en(link.dll_en),
		.buf_dis_en(link.buf_dis_en), .wr_term(link.wr_term), .refresh(link.refresh));
	// 100 ns period
	always #50 sys_clk = ~sys_clk;
	task automatic chk(logic [7:0] got, logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// the sequence needs a few hundred cycles; 2000 means a hang
	initial begin
		#200000;
		err_count++;
		finish_test();
	end
	initial begin
		repeat (8) @(negedge sys_clk);
		chk(8'({term_sel, async_mode, power_down, wr_term_err, busy, link.cke}), 8'h00);
		rstn = 1;
		$display("reset done");
		foreach (ROWS[i]) begin
			{dll, odt_req, wr} = ROWS[i][4:2];
			repeat (12) @(negedge sys_clk);
			chk(8'(term_sel), 8'(ROWS[i][1:0]));
			chk(8'({async_mode, wr_term_err}), 8'({!dll, 1'b0}));
		end
		$display("table done");
		// async answer lands one edge after the link moves
		dll = 0;
		wr = 0;
		repeat (12) @(negedge sys_clk);
		for (int v = 1; v >= 0; v--) begin
			odt_req = v[0];
			@(negedge sys_clk);
			while (link.odt_o !== v[0]) @(negedge sys_clk);
			chk(8'(term_sel), 8'(!v[0]));
			@(negedge sys_clk);
			chk(8'(term_sel), 8'(v[0]));
		end
		// ext temp held from the start; the second pass claims a single-rate part
		for (int k = 0; k < 2; k++) begin
			srr = k[0];
			while (link.refresh !== 1'b1) @(negedge sys_clk);
			n = 1;
			@(negedge sys_clk);
			while (link.refresh !== 1'b1) begin
				n++;
				@(negedge sys_clk);
			end
			chk(8'(n), k ? 8'(ODTC_TREFI_NORM_CYC) : 8'(ODTC_TREFI_EXT_CYC));
		end
		$display("latency done");
		// odt high yet park expected once the buffer is off
		bdis = 1;
		odt_req = 1;
		repeat (12) @(negedge sys_clk);
		pd_req = 1;
		while (link.cke !== 1'b0) @(negedge sys_clk);
		chk(8'(term_sel), 8'(ODTC_TERM_NOM));
		// odt still driven high here, so only the buffer disable can give park
		@(negedge sys_clk);
		chk(8'({link.odt_oe, link.odt_o, term_sel}), 8'h0C);
		repeat (6) @(negedge sys_clk);
		chk(8'({link.odt_oe, power_down, term_sel}), 8'h04);
		pd_req = 0;
		while (link.cke !== 1'b1) @(negedge sys_clk);
		chk(8'({link.odt_oe, link.odt_o}), 8'h02);
		repeat (12) @(negedge sys_clk);
		chk(8'({busy, term_sel}), 8'h01);
		$display("power-down done");
		// reset in mid entry must drop everything and restart cleanly
		pd_req = 1;
		while (link.cke !== 1'b0) @(negedge sys_clk);
		rstn = 0;
		pd_req = 0;
		@(negedge sys_clk);
		chk(8'({term_sel, async_mode, power_down, wr_term_err, busy, link.cke}), 8'h00);
		rstn = 1;
		@(negedge sys_clk);
		chk(8'({busy, link.cke, link.odt_oe}), 8'h03);
		$display("mid-run reset done");
		finish_test();
	end
endmodule
